// file: logic/isp_pkg.sv
// shared constants and types for the two-wire register target port
`default_nettype none

package isp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // clock and bus rates
    localparam int unsigned CLOCK_HZ     = 100_000_000;
    localparam int unsigned FAST_MODE_HZ = 400_000;
    // system cycles per fast-mode bit, the tightest case to sample
    localparam int unsigned BIT_CYCLES   = CLOCK_HZ / FAST_MODE_HZ;

    ////////////////////////////////////////////////////////////////////////////////
    // address and framing
    localparam logic [5:0] TARGET_ADDR_HIGH = 6'h0c;
    localparam logic [3:0] BYTE_BITS        = 4'h8;
    localparam logic [3:0] MSB_INDEX        = 4'h7;
    localparam int unsigned REG_ADDR_W      = 7;
    localparam int unsigned INC_BIT         = 7;
    localparam logic        RW_READ         = 1'b1;
    localparam logic [6:0]  PTR_STEP        = 7'h01;
    localparam int unsigned FIFO_DEPTH      = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ADDR_ACK  = 4'h2,
        ST_PTR       = 4'h3,
        ST_PTR_ACK   = 4'h4,
        ST_WDATA     = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA     = 4'h7,
        ST_RACK      = 4'h8
    } isp_state_t;

    typedef struct packed {
        logic cs;
        logic scl;
        logic sda;
        logic sa0;
    } isp_pads_t;

    localparam isp_pads_t PADS_IDLE = '{cs: 1'b1, scl: 1'b1, sda: 1'b1, sa0: 1'b0};

    typedef struct packed {
        logic [REG_ADDR_W-1:0] addr;
        logic [7:0]            data;
    } isp_write_t;

    localparam int unsigned WRITE_W = $bits(isp_write_t);

endpackage

`default_nettype wire

// file: logic/isp_fifo.sv
// write-word fifo with registered output stage
`timescale 1ns/1ps
`default_nettype none

module isp_fifo #(
    parameter int unsigned WIDTH = 15,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rstn,
    // fill side
    input  wire logic             i_valid,
    input  wire logic [WIDTH-1:0] i_data,
    output var  logic             o_ready,
    // drain side
    output var  logic             o_valid,
    output var  logic [WIDTH-1:0] o_data,
    input  wire logic             i_ready
);

    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0]   count;
        logic          out_valid;
        logic [WIDTH-1:0] out_data;
    } isp_fifo_state_t;

    isp_fifo_state_t  r_reg;
    isp_fifo_state_t  r_next;
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic             push;
    logic             load;

    ////////////////////////////////////////////////////////////////////////////////
    // flow
    assign o_ready = r_reg.count != (AW+1)'(DEPTH);
    assign o_valid = r_reg.out_valid;
    assign o_data  = r_reg.out_data;
    assign push    = i_valid && o_ready;
    // output stage refills as soon as it empties or is taken
    assign load    = (r_reg.count != '0) && (!r_reg.out_valid || i_ready);

    always_comb
    begin
        r_next = r_reg;
        if (push)
        begin
            r_next.wptr = r_reg.wptr + AW'(1);
        end
        if (load)
        begin
            r_next.rptr      = r_reg.rptr + AW'(1);
            r_next.out_data  = mem_reg[r_reg.rptr];
            r_next.out_valid = 1'b1;
        end
        else if (r_reg.out_valid && i_ready)
        begin
            r_next.out_valid = 1'b0;
        end
        r_next.count = r_reg.count + (AW+1)'(push) - (AW+1)'(load);
    end

    always_ff @(posedge i_clock)
    begin
        if (push)
        begin
            mem_reg[r_reg.wptr] <= i_data;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

endmodule

`default_nettype wire

// file: logic/isp_top.sv
// two-wire register target port with shared serial pads
`timescale 1ns/1ps
`default_nettype none

module isp_top
    import isp_pkg::*;
#(
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_rstn,
    // shared pads
    input  wire logic                  i_cs_pad,
    input  wire logic                  i_scl_pad,
    input  wire logic                  i_sda_pad,
    output var  logic                  o_sda_out,
    output var  logic                  o_sda_oen,
    input  wire logic                  i_sa0_pad,
    output var  logic                  o_sdo_out,
    output var  logic                  o_sdo_oen,
    // mode
    input  wire logic                  i_three_wire_select,
    output var  logic                  o_i2c_mode,
    output var  logic                  o_bus_busy,
    // serial peripheral engine side
    output var  logic                  o_spi_clk,
    output var  logic                  o_spi_din,
    input  wire logic                  i_spi_dout,
    input  wire logic                  i_spi_drive,
    // register read port
    output var  logic                  o_rd_req,
    output var  logic [REG_ADDR_W-1:0] o_rd_addr,
    input  wire logic [7:0]            i_rd_data,
    // register write stream
    output var  logic                  o_wr_valid,
    output var  logic [REG_ADDR_W-1:0] o_wr_addr,
    output var  logic [7:0]            o_wr_data,
    input  wire logic                  i_wr_ready
);

    typedef struct packed {
        isp_state_t            st;
        logic [3:0]            bitcnt;
        logic [7:0]            shreg;
        logic [REG_ADDR_W-1:0] ptr;
        logic                  inc;
        logic                  rw;
        logic                  acked;
        logic [7:0]            tx;
        logic [7:0]            rdbuf;
        logic                  rd_req;
        logic                  rd_pend;
        logic                  sda_low;
        logic                  busy;
        logic                  push;
        isp_write_t            word;
        isp_pads_t             sync1;
        isp_pads_t             sync2;
        isp_pads_t             prev;
        logic                  i2c_mode;
        logic                  sda_out;
        logic                  sda_oen;
        logic                  sdo_out;
        logic                  sdo_oen;
        logic                  spi_clk;
        logic                  spi_din;
    } isp_core_t;

    isp_core_t  r_reg;
    isp_core_t  r_next;
    logic       scl_rise;
    logic       scl_fall;
    logic       start;
    logic       stop;
    logic       quiet;
    logic       byte_done;
    logic       addr_match;
    logic       tx_bit;
    logic       fifo_ready;
    isp_write_t fifo_word;

    ////////////////////////////////////////////////////////////////////////////////
    // bus events from the second sync stage
    // two-stage sampling leaves ample margin
    assign scl_rise   = r_reg.sync2.scl && !r_reg.prev.scl;
    assign scl_fall   = !r_reg.sync2.scl && r_reg.prev.scl;
    assign start      = r_reg.sync2.scl && r_reg.prev.scl && r_reg.prev.sda && !r_reg.sync2.sda;
    assign stop       = r_reg.sync2.scl && r_reg.prev.scl && !r_reg.prev.sda && r_reg.sync2.sda;
    assign quiet      = r_reg.i2c_mode && !start && !stop;
    assign byte_done  = r_reg.bitcnt == BYTE_BITS;
    assign addr_match = r_reg.shreg[7:1] == {TARGET_ADDR_HIGH, r_reg.sync2.sa0};
    assign tx_bit     = r_reg.tx[3'(MSB_INDEX - r_reg.bitcnt)];

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        r_next         = r_reg;
        r_next.sync1   = '{cs: i_cs_pad, scl: i_scl_pad, sda: i_sda_pad, sa0: i_sa0_pad};
        r_next.sync2   = r_reg.sync1;
        r_next.prev    = r_reg.sync2;
        r_next.i2c_mode = r_reg.sync2.cs;
        r_next.rd_req  = 1'b0;
        r_next.push    = 1'b0;
        r_next.rd_pend = r_reg.rd_req;
        if (r_reg.rd_pend)
        begin
            r_next.rdbuf = i_rd_data;
        end
        if (!r_reg.i2c_mode)
        begin
            r_next.st      = ST_IDLE;
            r_next.busy    = 1'b0;
            r_next.sda_low = 1'b0;
        end
        // start or repeated start, pointer kept
        else if (start)
        begin
            r_next.st      = ST_ADDR;
            r_next.bitcnt  = '0;
            r_next.busy    = 1'b1;
            r_next.sda_low = 1'b0;
        end
        else if (stop)
        begin
            r_next.st      = ST_IDLE;
            r_next.busy    = 1'b0;
            r_next.sda_low = 1'b0;
        end
        else if (scl_rise)
        begin
            case (r_reg.st)
                ST_ADDR, ST_PTR, ST_WDATA:
                begin
                    r_next.shreg  = {r_reg.shreg[6:0], r_reg.sync2.sda};
                    r_next.bitcnt = r_reg.bitcnt + 4'h1;
                end
                ST_RDATA:
                begin
                    r_next.bitcnt = r_reg.bitcnt + 4'h1;
                end
                ST_RACK:
                begin
                    r_next.acked = !r_reg.sync2.sda;
                end
                default:
                begin
                end
            endcase
        end
        else if (scl_fall)
        begin
            case (r_reg.st)
                ST_ADDR:
                begin
                    if (byte_done)
                    begin
                        if (addr_match)
                        begin
                            r_next.st      = ST_ADDR_ACK;
                            r_next.sda_low = 1'b1;
                            r_next.rw      = r_reg.shreg[0];
                            r_next.rd_req  = r_reg.shreg[0] == RW_READ;
                        end
                        // leave line high, stay busy till stop
                        else
                        begin
                            r_next.st = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    r_next.bitcnt = '0;
                    // read direction goes straight to data
                    if (r_reg.rw == RW_READ)
                    begin
                        r_next.st      = ST_RDATA;
                        r_next.tx      = r_reg.rdbuf;
                        r_next.sda_low = !r_reg.rdbuf[7];
                    end
                    else
                    begin
                        r_next.st      = ST_PTR;
                        r_next.sda_low = 1'b0;
                    end
                end
                ST_PTR:
                begin
                    if (byte_done)
                    begin
                        r_next.st      = ST_PTR_ACK;
                        r_next.sda_low = 1'b1;
                        r_next.ptr     = r_reg.shreg[REG_ADDR_W-1:0];
                        r_next.inc     = r_reg.shreg[INC_BIT];
                    end
                end
                ST_PTR_ACK, ST_WDATA_ACK:
                begin
                    r_next.st      = ST_WDATA;
                    r_next.sda_low = 1'b0;
                    r_next.bitcnt  = '0;
                    if (r_reg.st == ST_WDATA_ACK && r_reg.inc)
                    begin
                        r_next.ptr = r_reg.ptr + PTR_STEP;
                    end
                end
                ST_WDATA:
                begin
                    if (byte_done)
                    begin
                        // ack only what the fifo can hold
                        if (fifo_ready)
                        begin
                            r_next.st      = ST_WDATA_ACK;
                            r_next.sda_low = 1'b1;
                            r_next.push    = 1'b1;
                            r_next.word    = '{addr: r_reg.ptr, data: r_reg.shreg};
                        end
                        else
                        begin
                            r_next.st = ST_IDLE;
                        end
                    end
                end
                ST_RDATA:
                begin
                    if (byte_done)
                    begin
                        r_next.st      = ST_RACK;
                        r_next.sda_low = 1'b0;
                        r_next.rd_req  = 1'b1;
                        if (r_reg.inc)
                        begin
                            r_next.ptr = r_reg.ptr + PTR_STEP;
                        end
                    end
                    else
                    begin
                        r_next.sda_low = !tx_bit;
                    end
                end
                ST_RACK:
                begin
                    if (r_reg.acked)
                    begin
                        r_next.st      = ST_RDATA;
                        r_next.bitcnt  = '0;
                        r_next.tx      = r_reg.rdbuf;
                        r_next.sda_low = !r_reg.rdbuf[7];
                    end
                    else
                    begin
                        r_next.st = ST_IDLE;
                    end
                end
                default:
                begin
                    r_next.st = ST_IDLE;
                end
            endcase
        end
        // pad roles follow the active protocol
        r_next.spi_clk = r_reg.sync2.scl;
        r_next.spi_din = r_reg.sync2.sda;
        if (r_reg.i2c_mode)
        begin
            r_next.sda_out = 1'b0;
            r_next.sda_oen = !r_next.sda_low;
            r_next.sdo_out = 1'b0;
            r_next.sdo_oen = 1'b1;
        end
        // three-wire drives data pad, four-wire the sdo pad
        else
        begin
            r_next.sda_out = i_spi_dout;
            r_next.sda_oen = !(i_spi_drive && i_three_wire_select);
            r_next.sdo_out = i_spi_dout;
            r_next.sdo_oen = !(i_spi_drive && !i_three_wire_select);
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            r_reg          <= '0;
            r_reg.sync1    <= PADS_IDLE;
            r_reg.sync2    <= PADS_IDLE;
            r_reg.prev     <= PADS_IDLE;
            r_reg.i2c_mode <= 1'b1;
            r_reg.sda_oen  <= 1'b1;
            r_reg.sdo_oen  <= 1'b1;
            r_reg.spi_clk  <= 1'b1;
            r_reg.spi_din  <= 1'b1;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write fifo; a full fifo turns into a withheld ack
    isp_fifo #(
        .WIDTH (WRITE_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_valid (r_reg.push),
        .i_data  (r_reg.word),
        .o_ready (fifo_ready),
        .o_valid (o_wr_valid),
        .o_data  (fifo_word),
        .i_ready (i_wr_ready)
    );

    assign o_wr_addr  = fifo_word.addr;
    assign o_wr_data  = fifo_word.data;
    assign o_sda_out  = r_reg.sda_out;
    assign o_sda_oen  = r_reg.sda_oen;
    assign o_sdo_out  = r_reg.sdo_out;
    assign o_sdo_oen  = r_reg.sdo_oen;
    assign o_i2c_mode = r_reg.i2c_mode;
    assign o_bus_busy = r_reg.busy;
    assign o_spi_clk  = r_reg.spi_clk;
    assign o_spi_din  = r_reg.spi_din;
    assign o_rd_req   = r_reg.rd_req;
    assign o_rd_addr  = r_reg.ptr;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);

    sequence s_addr_byte;
        quiet && scl_fall && r_reg.st == ST_ADDR && byte_done;
    endsequence

    sequence s_wdata_byte;
        quiet && scl_fall && r_reg.st == ST_WDATA && byte_done;
    endsequence

    mode_pad_sel_a: assert property (
        $stable(i_cs_pad)[*4] |-> o_i2c_mode == i_cs_pad)
        else $error("mode does not follow cs pad");

    start_busy_a: assert property (
        r_reg.i2c_mode && start |=> o_bus_busy && r_reg.st == ST_ADDR && r_reg.bitcnt == '0)
        else $error("start not taken");

    stop_idle_a: assert property (
        r_reg.i2c_mode && stop |=> r_reg.st == ST_IDLE && !o_bus_busy ##1 o_sda_oen)
        else $error("stop did not return idle");

    addr_match_a: assert property (
        s_addr_byte ##0 addr_match |=> r_reg.st == ST_ADDR_ACK ##1 !o_sda_oen)
        else $error("own address not acknowledged");

    addr_nomatch_a: assert property (
        s_addr_byte ##0 !addr_match |=> r_reg.st == ST_IDLE ##1 o_sda_oen)
        else $error("foreign address acknowledged");

    ack_hold_a: assert property (
        quiet && !scl_fall && r_reg.st inside {ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK}
        |=> r_reg.sda_low && !o_sda_oen)
        else $error("ack released early");

    wr_push_a: assert property (
        s_wdata_byte ##0 fifo_ready |=> r_reg.push && r_reg.word.data == $past(r_reg.shreg))
        else $error("written byte not queued");

    ptr_inc_a: assert property (
        quiet && scl_fall && r_reg.st == ST_WDATA_ACK && r_reg.inc
        |=> r_reg.ptr == REG_ADDR_W'($past(r_reg.ptr) + PTR_STEP))
        else $error("pointer not advanced");

    msb_first_a: assert property (
        quiet && scl_fall && r_reg.st == ST_RDATA && !byte_done
        |=> r_reg.sda_low == !$past(tx_bit))
        else $error("read bit order wrong");

    ptr_kept_a: assert property (
        r_reg.i2c_mode && start |=> $stable(r_reg.ptr))
        else $error("pointer lost at start");

endmodule

`default_nettype wire

// file: verification/isp_ctl_model.sv
// behavioural two-wire bus controller that drives the shared pads
`timescale 1ns/1ps
`default_nettype none

module isp_ctl_model (
    // bus lines; data is open drain with a pull-up
    output var  logic o_scl,
    output var  logic o_sda_low,
    input  wire logic i_sda
);
    // quarter of the 125 ns bus clock; the clock stands high between frames
    localparam realtime QTR = 31.25;

    initial
    begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    ////////////////////////////////////////
    // start or repeated start
    task automatic start();
        o_sda_low = 1'b0;
        #QTR o_scl = 1'b1;
        #QTR o_sda_low = 1'b1;
        #QTR o_scl = 1'b0;
        #QTR;
    endtask

    // stop, data rises while clock high
    task automatic stop();
        o_sda_low = 1'b1;
        #QTR o_scl = 1'b1;
        #QTR o_sda_low = 1'b0;
        #QTR;
    endtask

    ////////////////////////////////////////
    // byte msb first, then the acknowledge slot
    task automatic xfer(
        input  logic [7:0] tx,
        input  logic       ack_drv,
        output logic [7:0] rx,
        output logic       line
    );
        for (int i = 7; i >= 0; i--)
        begin
            o_sda_low = ~tx[i];
            #QTR o_scl = 1'b1;
            #QTR rx[i] = i_sda;
            #QTR o_scl = 1'b0;
            #QTR;
        end
        // released in the slot unless acking a read byte
        o_sda_low = ack_drv;
        #QTR o_scl = 1'b1;
        #QTR line = i_sda;
        #QTR o_scl = 1'b0;
        #QTR;
    endtask
endmodule

`default_nettype wire

// file: verification/isp_top_bench.sv
// bench for the two-wire register target port
`timescale 1ns/1ps
`default_nettype none

module isp_top_bench;
    import isp_pkg::*;

    localparam int DEPTH = FIFO_DEPTH;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        cs = 1'b1;
    logic        sa0 = 1'b1;
    logic        tws = 1'b0;
    logic        sdout = 1'b1;
    logic        sdrive = 1'b0;
    logic        wrdy = 1'b1;
    logic [7:0]  rdata = 8'h00;
    logic [7:0]  rx;
    logic        line;
    logic        scl, sda_low, sda_oen, sda_out, sdo_oen, mode, busy, rd_req, wvalid;
    logic        sdo_out, spi_clk, spi_din;
    logic [6:0]  rd_addr, waddr;
    logic [7:0]  wdata;
    logic [14:0] got_q[$];
    logic [14:0] exp_q[$];
    int          err_count = 0;
    int          checks = 0;
    // pull-up wire: low if either side pulls it
    wire logic   sda = !sda_low && (sda_oen || sda_out);

    initial
    begin
        forever #5 clk = ~clk;
    end

    isp_top #(.DEPTH(DEPTH)) dut (
        .i_clock(clk), .i_rstn(rstn), .i_cs_pad(cs), .i_scl_pad(scl), .i_sda_pad(sda),
        .o_sda_out(sda_out), .o_sda_oen(sda_oen), .i_sa0_pad(sa0), .o_sdo_out(sdo_out),
        .o_sdo_oen(sdo_oen), .i_three_wire_select(tws), .o_i2c_mode(mode),
        .o_bus_busy(busy), .o_spi_clk(spi_clk), .o_spi_din(spi_din), .i_spi_dout(sdout),
        .i_spi_drive(sdrive), .o_rd_req(rd_req), .o_rd_addr(rd_addr), .i_rd_data(rdata),
        .o_wr_valid(wvalid), .o_wr_addr(waddr), .o_wr_data(wdata), .i_wr_ready(wrdy)
    );

    isp_ctl_model ctl (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));

    // register file stand-in: data one cycle after the request
    always @(posedge clk)
    begin
        if (rd_req)
            rdata <= {1'b0, rd_addr} ^ 8'h5a;
        if (wvalid && wrdy)
            got_q.push_back({waddr, wdata});
    end

    ////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic send(input logic [7:0] b, input logic acked);
        ctl.xfer(b, 1'b0, rx, line);
        chk("ack", {15'h0, acked}, {15'h0, ~line});
    endtask

    // write burst; bytes past nacked are refused
    task automatic wr(input logic [7:0] ptr, input int n, input int nacked);
        ctl.start();
        send(8'h30, 1'b1);
        send(ptr, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            send(8'(8'hc0 + i), i < nacked);
            if (i < nacked)
                exp_q.push_back({ptr[6:0] + (ptr[7] ? 7'(i) : 7'h0), 8'(8'hc0 + i)});
        end
        ctl.stop();
    endtask

    task automatic rd(input logic [7:0] ptr, input int n);
        ctl.start();
        send(8'h30, 1'b1);
        send(ptr, 1'b1);
        ctl.start();
        send(8'h31, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            ctl.xfer(8'hff, i < n - 1, rx, line);
            chk("rdata", {9'h0, ptr[6:0] + (ptr[7] ? 7'(i) : 7'h0)} ^ 16'h5a, {8'h0, rx});
        end
        ctl.stop();
    endtask

    task automatic give_verdict();
        if (err_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (10) @(posedge clk);
        ctl.start();
        repeat (20) @(negedge clk);
        chk("busy", 16'h1, {15'h0, busy});
        send(8'h32, 1'b1);
        send(8'h85, 1'b1);
        send(8'ha5, 1'b1);
        send(8'h3c, 1'b1);
        ctl.stop();
        repeat (20) @(negedge clk);
        chk("busy", 16'h0, {15'h0, busy});
        exp_q.push_back({7'h05, 8'ha5});
        exp_q.push_back({7'h06, 8'h3c});
        ctl.start();
        send(8'h30, 1'b0);
        ctl.stop();
        @(posedge clk) sa0 <= 1'b0;
        wr(8'h07, 2, 2);
        rd(8'h90, 3);
        rd(8'h22, 2);
        // sink stalls: the fifo fills, then the next byte is refused
        @(posedge clk) wrdy <= 1'b0;
        wr(8'hfc, DEPTH + 2, DEPTH + 1);
        @(posedge clk) wrdy <= 1'b1;
        for (int i = 0; i < 300 && got_q.size() < exp_q.size(); i++)
            @(posedge clk);
        // drain wait ran out: count it as a mismatch of its own
        if (got_q.size() < exp_q.size())
            err_count++;
        chk("words", 16'(exp_q.size()), 16'(got_q.size()));
        foreach (exp_q[i])
            chk("word", 16'(exp_q[i]), 16'(got_q[i]));
        // peripheral mode: pads handed over, three-wire then four-wire
        @(posedge clk)
        begin
            cs <= 1'b0;
            tws <= 1'b1;
            sdrive <= 1'b1;
            sdout <= 1'b0;
        end
        repeat (8) @(negedge clk);
        chk("mode", 16'h0, {15'h0, mode});
        chk("sda_oen", 16'h0, {15'h0, sda_oen});
        chk("spi_din", 16'h0, {15'h0, spi_din});
        chk("spi_clk", 16'h1, {15'h0, spi_clk});
        // data pad released again; synced copy needs four edges to follow
        @(posedge clk)
        begin
            tws <= 1'b0;
            sdout <= 1'b1;
        end
        repeat (6) @(negedge clk);
        chk("sdo_oen", 16'h0, {15'h0, sdo_oen});
        chk("sdo_out", 16'h1, {15'h0, sdo_out});
        chk("sda_oen", 16'h1, {15'h0, sda_oen});
        chk("spi_din", 16'h1, {15'h0, spi_din});
        give_verdict();
    end
endmodule

`default_nettype wire
